// ===== rtl/flm_consts.vh
`ifndef FLM_CONSTS_VH
`define FLM_CONSTS_VH
`define FLM_ADDR_CTRL 4'h0
`define FLM_ADDR_DISP 4'h1
`define FLM_ADDR_SPEED 4'h2
`define FLM_ADDR_RAMP 4'h3
`define FLM_ADDR_STAT 4'h4
`define FLM_ADDR_IRQ_ST 4'h5
`define FLM_ADDR_IRQ_MSK 4'h6
`define FLM_ADDR_REFCNT 4'h7
`define FLM_ADDR_STATE 4'h8
`define FLM_CTRL_ENABLE 0
`define FLM_CTRL_UNLOCK_REQ 1
`define FLM_CTRL_FAST_SEL 2
`define FLM_CTRL_EDGE_LSB 3
`define FLM_CTRL_RST 32'h0000_000A
`define FLM_DISP_RST 31'h0000_2710
`define FLM_DISP_MAX 31'h4000_0000
`define FLM_SPEED_RST 13'h00C8
`define FLM_SPEED_MAX 13'h1770
`define FLM_RAMP_RST 10'h00A
`define FLM_MIN_RPM 13'h000A
`define FLM_EDGE_FALL0 3'h0
`define FLM_EDGE_RISE1 3'h1
`define FLM_EDGE_RISE2 3'h2
`define FLM_EDGE_FALL3 3'h3
`define FLM_EDGE_BOTH 3'h4
`define FLM_IRQ_DONE 0
`define FLM_IRQ_REJECT 1
`define FLM_IRQ_UNLOCK 2
`endif

// ===== rtl/flm_fixed_length_move.v
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "flm_consts.vh"
// fixed-length interrupt move controller; the motion profile itself runs
// outside, this block arbitrates references and issues the fixed distance
// the block never generates pulses on its own: it hands a distance, a
// speed and a ramp to the profile and then only gates and counts what
// comes back, so the profile can be swapped without touching this logic
// all drive-state inputs are assumed to share core_clk; only the pins sync
module flm_fixed_length_move (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_ff,
  // drive state, same clock domain
  input wire servo_on,
  input wire position_mode,
  input wire homing_active,
  input wire motor_dir,
  input wire [12:0] motor_speed_rpm,
  input wire inhibit_input_function,
  input wire unlock_input_function,
  // asynchronous pins
  input wire fast_trigger_input,
  input wire move_inhibit_input,
  input wire move_unlock_input,
  // ordinary position references from other sources
  input wire ext_ref_valid,
  input wire [15:0] ext_ref_pulses,
  // motion profile handshake
  output reg move_start_ff,
  output reg move_dir_ff,
  output reg [30:0] move_dist_ff,
  output reg [12:0] move_speed_ff,
  output reg [9:0] move_ramp_ff,
  input wire move_ref_valid,
  input wire [15:0] move_ref_pulses,
  input wire move_finished,
  // reference gating and filter
  output wire ref_accept,
  output wire filter_bypass,
  output reg [31:0] input_reference_counter_ff,
  // digital outputs and interrupt
  output reg move_done_output_ff,
  output reg positioning_done_output_ff,
  output wire irq
);

  // sequence states; the codes are visible in the status register, so
  // software that decodes them depends on these exact values
  // idle accepts references, run shields them, lock waits for unlock
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_LOCK = 2'h2;

  // settings; only the low six control bits exist, the rest read zero
  // so that later additions cannot change what old software sees
  reg [31:0] ctrl_ff;
  reg [30:0] disp_ff;
  reg [12:0] speed_ff;
  reg [9:0] ramp_ff;
  wire [2:0] irq_st;
  reg [2:0] irq_msk_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [2:0] trig_sync_ff;
  reg [1:0] inh_sync_ff;
  reg [1:0] unl_sync_ff;
  reg trig_edge;
  reg trig_ok;
  reg [12:0] cruise;
  reg [2:0] ev;

  wire fly_move_enable = ctrl_ff[`FLM_CTRL_ENABLE];
  wire fly_move_unlock_required = ctrl_ff[`FLM_CTRL_UNLOCK_REQ];
  wire fast_input_function_select = ctrl_ff[`FLM_CTRL_FAST_SEL];
  wire [2:0] fast_input_edge_select = ctrl_ff[`FLM_CTRL_EDGE_LSB+2:
                                              `FLM_CTRL_EDGE_LSB];
  wire trig_q = trig_sync_ff[1];
  wire trig_q_d = trig_sync_ff[2];
  wire inhibit_valid = inhibit_input_function & inh_sync_ff[1];
  wire unlock_valid = unlock_input_function & unl_sync_ff[1];

  // one decoded write enable per register keeps the write process flat
  // and lets the sticky flags share the same decode as the settings
  wire wr_ctrl = reg_wr & (reg_addr == `FLM_ADDR_CTRL);
  wire wr_disp = reg_wr & (reg_addr == `FLM_ADDR_DISP);
  wire wr_speed = reg_wr & (reg_addr == `FLM_ADDR_SPEED);
  wire wr_ramp = reg_wr & (reg_addr == `FLM_ADDR_RAMP);
  wire wr_irq_st = reg_wr & (reg_addr == `FLM_ADDR_IRQ_ST);
  wire wr_irq_msk = reg_wr & (reg_addr == `FLM_ADDR_IRQ_MSK);

  // pins pass two flops; the third stage only feeds the edge detector
  // the stages reset low, matching the idle pin level, so no false
  // edge appears right after reset when the trigger pin rests low
  always @(posedge core_clk) begin
    if (!rst_n) begin
      trig_sync_ff <= 3'h0;
      inh_sync_ff <= 2'h0;
      unl_sync_ff <= 2'h0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[1:0], fast_trigger_input};
      inh_sync_ff <= {inh_sync_ff[0], move_inhibit_input};
      unl_sync_ff <= {unl_sync_ff[0], move_unlock_input};
    end
  end

  // edge decode; level codes are treated as edges regardless
  // unused codes fall back to rising so a bad setting still gives one
  // start per edge instead of a start on every cycle of a level
  always @* begin
    case (fast_input_edge_select)
      `FLM_EDGE_FALL0, `FLM_EDGE_FALL3:
        trig_edge = trig_q_d & ~trig_q;
      `FLM_EDGE_RISE1, `FLM_EDGE_RISE2:
        trig_edge = ~trig_q_d & trig_q;
      `FLM_EDGE_BOTH:
        trig_edge = trig_q_d ^ trig_q;
      default:
        trig_edge = ~trig_q_d & trig_q;
    endcase
  end

  // cruise speed: zero means keep the prior speed if fast enough
  // the prior speed is sampled at the start, later changes are ignored
  always @* begin
    if (speed_ff == 13'h0000) begin
      cruise = motor_speed_rpm;
    end else begin
      cruise = speed_ff;
    end
  end

  // every start condition; a trigger while running never reaches idle logic
  // all terms are same-clock levels or synced pins, so a single cycle
  // decides and a start can never half-happen
  always @* begin
    trig_ok = trig_edge & fly_move_enable & fast_input_function_select
      & servo_on & position_mode
      & ~homing_active
      & (disp_ff != 31'h0000_0000)
      & ~inhibit_valid
      & ~((speed_ff == 13'h0000) & (motor_speed_rpm < `FLM_MIN_RPM));
  end

  // sequence: idle, run, optional lock
  // an unlock already present at the finish skips the lock entirely, so
  // a host holding the unlock pin gets back-to-back moves without a gap
  // clearing the unlock setting while locked also releases the lock
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (trig_ok) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (move_finished) begin
          if (fly_move_unlock_required && !unlock_valid) begin
            nxt_state = ST_LOCK;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_LOCK: begin
        if (unlock_valid || !fly_move_unlock_required) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // other references only pass in idle; buffered ones are simply dropped
  // the gate is combinational so the reference source sees it change in
  // the very cycle the move starts, with no stray reference slipping in
  assign ref_accept = (state_ff == ST_IDLE);
  // the filter stays off for as long as the function is enabled, since a
  // filtered tail would otherwise smear into the fixed distance
  assign filter_bypass = fly_move_enable;
  // level interrupt, high while any unmasked sticky flag is set
  assign irq = |(irq_st & irq_msk_ff);

  // events for the sticky status
  // each event is a one-cycle pulse; the sticky flags below hold it
  always @* begin
    ev = 3'h0;
    ev[`FLM_IRQ_DONE] = (state_ff == ST_RUN) & move_finished;
    ev[`FLM_IRQ_REJECT] = (state_ff == ST_IDLE) & trig_edge & ~trig_ok;
    ev[`FLM_IRQ_UNLOCK] = (state_ff == ST_LOCK) & (nxt_state == ST_IDLE);
  end

  // state, move command and done outputs
  // the command fields are latched only at a start, so a setting changed
  // during a move applies to the next move, never to the running one
  // the done outputs stay high until the next start clears them
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      move_start_ff <= 1'b0;
      move_dir_ff <= 1'b0;
      move_dist_ff <= 31'h0000_0000;
      move_speed_ff <= 13'h0000;
      move_ramp_ff <= 10'h000;
      move_done_output_ff <= 1'b0;
      positioning_done_output_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      move_start_ff <= (state_ff == ST_IDLE) & trig_ok;
      if ((state_ff == ST_IDLE) && trig_ok) begin
        move_dir_ff <= motor_dir;
        move_dist_ff <= disp_ff;
        move_speed_ff <= cruise;
        move_ramp_ff <= ramp_ff;
        move_done_output_ff <= 1'b0;
        positioning_done_output_ff <= 1'b0;
      end else if (ev[`FLM_IRQ_DONE]) begin
        // both rise together, servo-on is not consulted
        move_done_output_ff <= 1'b1;
        positioning_done_output_ff <= 1'b1;
      end
    end
  end

  // reference counter: during the move only the move's own pulses
  // while locked nothing is counted; the counter simply wraps on overflow
  always @(posedge core_clk) begin
    if (!rst_n) begin
      input_reference_counter_ff <= 32'h0000_0000;
    end else if (state_ff == ST_RUN) begin
      if (move_ref_valid) begin
        input_reference_counter_ff <= input_reference_counter_ff
          + {16'h0000, move_ref_pulses};
      end
    end else if (ref_accept && ext_ref_valid) begin
      input_reference_counter_ff <= input_reference_counter_ff
        + {16'h0000, ext_ref_pulses};
    end
  end

  // register writes; displacement and speed clamp at their maxima
  // clamping rather than wrapping keeps an oversized value safe: the move
  // gets shorter or slower than asked, never a random short distance
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_ff <= `FLM_CTRL_RST;
      disp_ff <= `FLM_DISP_RST;
      speed_ff <= `FLM_SPEED_RST;
      ramp_ff <= `FLM_RAMP_RST;
      irq_msk_ff <= 3'h0;
    end else begin
      // control bits above the defined six are dropped
      if (wr_ctrl) begin
        ctrl_ff <= {26'h0, reg_wdata[5:0]};
      end
      // displacement, zero is legal and blocks every start
      if (wr_disp) begin
        if (reg_wdata > {1'b0, `FLM_DISP_MAX}) begin
          disp_ff <= `FLM_DISP_MAX;
        end else begin
          disp_ff <= reg_wdata[30:0];
        end
      end
      // cruise speed, zero selects the prior motor speed
      if (wr_speed) begin
        if (reg_wdata > {19'h0, `FLM_SPEED_MAX}) begin
          speed_ff <= `FLM_SPEED_MAX;
        end else begin
          speed_ff <= reg_wdata[12:0];
        end
      end
      // ramp time, clamped at its largest setting
      if (wr_ramp) begin
        ramp_ff <= (reg_wdata > 32'h0000_03E8) ? 10'h3E8 : reg_wdata[9:0];
      end
      // interrupt mask, same layout as the sticky flags
      if (wr_irq_msk) begin
        irq_msk_ff <= reg_wdata[2:0];
      end
    end
  end

  // sticky event flags, one flop per bit; the event wins over a
  // write-one-to-clear in the same cycle, so software never loses an
  // event that arrived while it was clearing an older one
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sticky
      reg flag_ff;
      wire clr_hit = wr_irq_st & reg_wdata[gi];
      always @(posedge core_clk) begin
        if (!rst_n) begin
          flag_ff <= 1'b0;
        end else if (ev[gi]) begin
          flag_ff <= 1'b1;
        end else if (clr_hit) begin
          flag_ff <= 1'b0;
        end
      end
      assign irq_st[gi] = flag_ff;
    end
  endgenerate

  // read data one cycle after the strobe; unmapped reads as zero
  // the data return to zero between reads, so a stale value can never
  // be mistaken for a fresh answer by a master that samples late
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FLM_ADDR_CTRL: reg_rdata_ff <= ctrl_ff;
        `FLM_ADDR_DISP: reg_rdata_ff <= {1'b0, disp_ff};
        `FLM_ADDR_SPEED: reg_rdata_ff <= {19'h0, speed_ff};
        `FLM_ADDR_RAMP: reg_rdata_ff <= {22'h0, ramp_ff};
        `FLM_ADDR_STAT: reg_rdata_ff <= {26'h0, inhibit_valid,
          unlock_valid, positioning_done_output_ff,
          move_done_output_ff, state_ff};
        `FLM_ADDR_IRQ_ST: reg_rdata_ff <= {29'h0, irq_st};
        `FLM_ADDR_IRQ_MSK: reg_rdata_ff <= {29'h0, irq_msk_ff};
        `FLM_ADDR_REFCNT: reg_rdata_ff <= input_reference_counter_ff;
        default: reg_rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

endmodule // flm_fixed_length_move

// ===== testbench/flm_profile_model.sv
`timescale 1ns/1ps
// stand-in motion profile: four unit references, then a finish pulse
module flm_profile_model (
  // clock and reset
  input logic core_clk,
  input logic rst_n,
  // start from the block
  input logic move_start_ff,
  // reference stream back
  output logic move_ref_valid,
  output logic [15:0] move_ref_pulses,
  output logic move_finished
);
  logic [2:0] left_ff;
  // countdown; restarts only on a fresh start pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) left_ff <= 3'h0;
    else if (move_start_ff) left_ff <= 3'h5;
    else if (left_ff != 3'h0) left_ff <= left_ff - 3'h1;
  end
  // idle data scrambles so stale pulses never look like a reference
  assign move_ref_valid = left_ff > 3'h1;
  assign move_ref_pulses = move_ref_valid ? 16'h0001 : {13'h0, left_ff} ^ 16'hA5A5;
  assign move_finished = left_ff == 3'h1;
endmodule // flm_profile_model

// ===== testbench/flm_fixed_length_move_monitor.sv
`timescale 1ns/1ps
// cycle-exact relations on the block's ports
module flm_monitor (
  // clock and reset
  input logic core_clk,
  input logic rst_n,
  // drive state and handshake
  input logic servo_on,
  input logic position_mode,
  input logic homing_active,
  input logic move_finished,
  input logic ref_accept,
  input logic move_start_ff,
  input logic [30:0] move_dist_ff,
  input logic move_done_output_ff,
  input logic positioning_done_output_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_done_pair: assert property (
    $rose(move_done_output_ff) |-> $rose(positioning_done_output_ff))
    else $error("done outputs rose apart");
  a_done_cause: assert property (
    $rose(move_done_output_ff) |-> $past(move_finished))
    else $error("done without finish pulse");
  a_start_idle: assert property (
    move_start_ff |-> $past(ref_accept))
    else $error("start outside idle");
  a_run_shield: assert property (
    move_start_ff |-> !ref_accept)
    else $error("references open during move");
  a_one_start: assert property (
    move_start_ff |=> !move_start_ff)
    else $error("start pulse too long");
  a_home_block: assert property (
    move_start_ff |-> !$past(homing_active))
    else $error("start while homing");
  a_servo_need: assert property (
    move_start_ff |-> $past(servo_on) && $past(position_mode))
    else $error("start without servo in position mode");
  a_zero_disp: assert property (
    move_start_ff |-> move_dist_ff != 31'h0)
    else $error("start with zero distance");
endmodule // flm_monitor
bind flm_fixed_length_move flm_monitor u_mon (.*);

// ===== testbench/flm_fixed_length_move_tb.sv
`timescale 1ns/1ps
module flm_fixed_length_move_tb;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, servo_on = 1;
  logic position_mode = 1, homing_active = 0, motor_dir = 0;
  logic inhibit_input_function = 1, unlock_input_function = 1;
  logic fast_trigger_input = 0, move_inhibit_input = 0, ext_ref_valid = 0;
  logic move_unlock_input = 0, move_start_ff, move_dir_ff, move_ref_valid;
  logic move_finished, ref_accept, filter_bypass, irq;
  logic move_done_output_ff, positioning_done_output_ff;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_ff, input_reference_counter_ff;
  logic [12:0] motor_speed_rpm = 13'h0064, move_speed_ff;
  logic [15:0] ext_ref_pulses = 16'h0005, move_ref_pulses;
  logic [30:0] move_dist_ff;
  logic [9:0] move_ramp_ff;
  int err_count = 0, checked = 0, starts = 0;
  flm_fixed_length_move i_dut (.*);
  flm_profile_model i_prof (.*);
  // clock and start counter
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (move_start_ff === 1'b1) starts <= starts + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata_ff, exp);
  endtask
  // toggle the fast pin, allow a whole move, count the starts
  task automatic trig(input int exp);
    int s;
    s = starts;
    @(posedge core_clk);
    fast_trigger_input <= ~fast_trigger_input;
    repeat (14) @(posedge core_clk);
    chk(starts - s, exp);
  endtask
  task automatic t_regs();
    rd(4'h0, 32'h0000_000A);
    rd(4'h1, 32'h0000_2710);
    rd(4'h2, 32'h0000_00C8);
    rd(4'h3, 32'h0000_000A);
    rd(4'h8, 32'h0000_0000);
    wr(4'h1, 32'h7FFF_FFFF);
    rd(4'h1, 32'h4000_0000);
    wr(4'h1, 32'h0000_2710);
  endtask
  task automatic t_edges();
    for (int c = 0; c < 5; c++) begin
      wr(4'h0, 32'h5 | (c << 3));
      trig((c == 1 || c == 2 || c == 4) ? 1 : 0);
      trig((c == 0 || c == 3 || c == 4) ? 1 : 0);
    end
    chk(filter_bypass, 1);
  endtask
  task automatic t_move();
    logic [31:0] c0;
    int s;
    int n;
    motor_dir <= 1'b1;
    s = starts;
    c0 = input_reference_counter_ff;
    @(posedge core_clk);
    fast_trigger_input <= ~fast_trigger_input;
    n = 0;
    while (move_start_ff !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    chk({move_dir_ff, move_dist_ff}, {1'b1, 31'h0000_2710});
    chk(move_speed_ff, 32'h0000_00C8);
    chk(move_ramp_ff, 32'h0000_000A);
    // second edge and foreign references land mid-move
    @(posedge core_clk);
    ext_ref_valid <= 1'b1;
    fast_trigger_input <= ~fast_trigger_input;
    repeat (3) @(posedge core_clk);
    ext_ref_valid <= 1'b0;
    repeat (12) @(negedge core_clk);
    chk({move_done_output_ff, positioning_done_output_ff}, 2'h3);
    chk(input_reference_counter_ff - c0, 32'h4);
    chk(starts - s, 1);
  endtask
  // each pass breaks exactly one start condition
  task automatic t_reject();
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk);
      homing_active <= (k == 0);
      servo_on <= (k != 1);
      move_inhibit_input <= (k == 2);
      motor_speed_rpm <= (k == 5) ? 13'h0009 : 13'h000A;
      if (k == 3) wr(4'h0, 32'h0000_0021);
      if (k == 4) wr(4'h1, 32'h0);
      if (k == 5) wr(4'h2, 32'h0);
      trig(0);
      wr(4'h0, 32'h0000_0025);
      wr(4'h1, 32'h0000_2710);
    end
    motor_speed_rpm <= 13'h000A;
    trig(1);
    chk(move_speed_ff, 32'h0000_000A);
    wr(4'h2, 32'h0000_00C8);
  endtask
  task automatic t_lock();
    wr(4'h5, 32'h7);
    wr(4'h6, 32'h1);
    wr(4'h0, 32'h0000_0027);
    trig(1);
    chk({ref_accept, irq}, 2'h1);
    rd(4'h5, 32'h1);
    trig(0);
    wr(4'h5, 32'h1);
    @(negedge core_clk);
    chk(irq, 0);
    @(posedge core_clk);
    move_unlock_input <= 1'b1;
    repeat (5) @(negedge core_clk);
    chk(ref_accept, 1);
  endtask
  task automatic summarize();
    $display("err_count=%0d checked=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_edges();
    t_move();
    t_reject();
    t_lock();
    summarize();
  end
  // hang guard, several times the expected run
  initial begin
    repeat (4000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule // flm_fixed_length_move_tb
